/* rtl/adcsq_pkg.sv */
// constants, types and helpers for the converter sequencer control block
package adcsq_pkg;

  // register byte addresses
  localparam logic [15:0] ADCSQ_ADDR_STATUS = 16'h0038;
  localparam logic [15:0] ADCSQ_ADDR_RESULT = 16'h0039;
  localparam logic [15:0] ADCSQ_ADDR_CLKCFG = 16'h003a;

  // conversion_status_control fields
  localparam int ADCSQ_CONV_COMPLETE_FLAG_BIT = 7;
  localparam int ADCSQ_IEN_BIT  = 6;
  localparam int ADCSQ_CONT_BIT = 5;
  localparam int ADCSQ_CHAN_MSB = 4;

  // conversion_clock_config fields
  localparam int ADCSQ_DIV_MSB  = 7;
  localparam int ADCSQ_DIV_LSB  = 5;
  localparam int ADCSQ_SRC_BIT  = 4;

  // channel codes
  localparam logic [4:0] ADCSQ_CHAN_OFF      = 5'h1f;
  localparam logic [4:0] ADCSQ_CHAN_HIGH_REF = 5'h1d;
  localparam logic [4:0] ADCSQ_CHAN_LOW_REF  = 5'h1e;
  localparam logic [4:0] ADCSQ_CHAN_PIN_CNT  = 5'h0f;

  // conversion timing in conversion clock ticks
  localparam int ADCSQ_CONV_TICKS   = 16;
  localparam int ADCSQ_RESULT_BITS  = 8;
  localparam int ADCSQ_SAMPLE_TICKS = ADCSQ_CONV_TICKS - ADCSQ_RESULT_BITS;

  typedef enum logic [2:0] {
    ADCSQ_IDLE   = 3'b001,
    ADCSQ_SAMPLE = 3'b010,
    ADCSQ_APPROX = 3'b100
  } adcsq_state_e;

  typedef struct packed {
    adcsq_state_e state;
    logic         pend;
    logic [4:0]   chan;
    logic         ien;
    logic         cont;
    logic         conv_complete_flag;
    logic         irq;
    logic [2:0]   div;
    logic         src;
    logic         ext_prev;
    logic [3:0]   div_cnt;
    logic [3:0]   tick_cnt;
    logic [7:0]   mask;
    logic [7:0]   dac;
    logic [7:0]   result;
    logic [7:0]   rdata;
    logic         done;
    logic         pwr_off;
    logic [14:0]  in_sel;
    logic         hi_sel;
    logic         lo_sel;
  } adcsq_state_s;

  localparam adcsq_state_s ADCSQ_RESET = '{
    state: ADCSQ_IDLE, chan: ADCSQ_CHAN_OFF, pwr_off: 1'b1, default: '0};

  // terminal count of the prescaler: ratio minus one
  function automatic logic [3:0] adcsq_div_limit(input logic [2:0] code);
    logic [3:0] lim;
    lim = 4'hf;
    if (!code[2]) begin
      lim = 4'((5'h01 << code[1:0]) - 5'h01);
    end
    return lim;
  endfunction

  // one-hot select of the pin inputs, zero for non-pin codes
  function automatic logic [14:0] adcsq_pin_decode(input logic [4:0] chan);
    logic [14:0] sel;
    sel = 15'h0000;
    if (chan < ADCSQ_CHAN_PIN_CNT) begin
      sel = 15'(16'h0001 << chan);
    end
    return sel;
  endfunction

endpackage

/* rtl/adcsq_control.sv */
// conversion sequencer, register file and interrupt logic of the 8-bit SAR converter
//
// Decided for this implementation: the plain strobed port.
module adcsq_control
  import adcsq_pkg::*;
#(
  parameter int P_SAMPLE_TICKS = ADCSQ_SAMPLE_TICKS
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_ext_ref_clock,
  input  wire logic        i_stop_mode,
  input  wire logic        i_comp_above,
  output logic      [7:0]  o_rdata,
  output logic             o_irq,
  output logic      [14:0] o_input_sel,
  output logic             o_high_ref_sel,
  output logic             o_low_ref_sel,
  output logic             o_power_off,
  output logic             o_sampling,
  output logic      [7:0]  o_dac_code,
  output logic             o_conv_done
);

  if (P_SAMPLE_TICKS < 1 || P_SAMPLE_TICKS + ADCSQ_RESULT_BITS > ADCSQ_CONV_TICKS + 1) begin : g_chk
    $error("adcsq_control: sample ticks out of range");
  end

  adcsq_state_s q;
  adcsq_state_s d;
  logic         wr_stat;
  logic         rd_res;
  logic         wr_clk;
  logic         clear;

  assign wr_stat = i_wr && (i_addr == ADCSQ_ADDR_STATUS);
  assign rd_res  = i_rd && (i_addr == ADCSQ_ADDR_RESULT);
  assign wr_clk  = i_wr && (i_addr == ADCSQ_ADDR_CLKCFG);
  assign clear   = wr_stat || rd_res;

  always_comb begin
    logic       src_tick;
    logic       tick;
    logic       start;
    logic       off;
    logic [7:0] kept;
    src_tick = 1'b0;
    tick     = 1'b0;
    start    = 1'b0;
    off      = 1'b0;
    kept     = 8'h00;
    d        = q;
    d.done   = 1'b0;
    d.ext_prev = i_ext_ref_clock;
    // read data stands only in the cycle after the strobe
    d.rdata  = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        ADCSQ_ADDR_STATUS: d.rdata = {q.conv_complete_flag, q.ien, q.cont, q.chan};
        ADCSQ_ADDR_RESULT: d.rdata = q.result;
        ADCSQ_ADDR_CLKCFG: d.rdata = {q.div, q.src, 4'h0};
        default:           d.rdata = 8'h00;
      endcase
    end
    if (wr_stat) begin
      d.ien  = i_wdata[ADCSQ_IEN_BIT];
      d.cont = i_wdata[ADCSQ_CONT_BIT];
      d.chan = i_wdata[ADCSQ_CHAN_MSB:0];
      // enabled: plain storage bit; disabled: any write clears it
      d.conv_complete_flag = i_wdata[ADCSQ_IEN_BIT] & i_wdata[ADCSQ_CONV_COMPLETE_FLAG_BIT];
      start  = 1'b1;
    end
    if (rd_res && !q.ien) begin
      d.conv_complete_flag = 1'b0;
    end
    if (clear) begin
      d.irq = 1'b0;
    end
    if (wr_clk) begin
      d.div = i_wdata[ADCSQ_DIV_MSB:ADCSQ_DIV_LSB];
      d.src = i_wdata[ADCSQ_SRC_BIT];
    end
    // bus clock ticks every cycle, reference clock on its rising edge
    src_tick = q.src ? 1'b1 : (i_ext_ref_clock & ~q.ext_prev);
    if (src_tick) begin
      if (q.div_cnt >= adcsq_div_limit(q.div)) begin
        d.div_cnt = 4'h0;
        tick      = 1'b1;
      end else begin
        d.div_cnt = q.div_cnt + 4'h1;
      end
    end
    off = &d.chan;
    if (i_stop_mode || off) begin
      // stop keeps the request so the conversion reruns on exit
      d.state = ADCSQ_IDLE;
      d.pend  = !off && (q.pend || start || q.state != ADCSQ_IDLE);
    end else if (start || q.pend) begin
      d.state    = ADCSQ_SAMPLE;
      d.pend     = 1'b0;
      d.tick_cnt = 4'h0;
      d.div_cnt  = 4'h0;
    end else begin
      unique case (q.state)
        ADCSQ_IDLE: begin
        end
        ADCSQ_SAMPLE: begin
          if (tick) begin
            if (q.tick_cnt == 4'(P_SAMPLE_TICKS - 1)) begin
              d.state = ADCSQ_APPROX;
              d.mask  = 8'h80;
              d.dac   = 8'h80;
            end else begin
              d.tick_cnt = q.tick_cnt + 4'h1;
            end
          end
        end
        ADCSQ_APPROX: begin
          if (tick) begin
            kept   = i_comp_above ? q.dac : (q.dac & ~q.mask);
            d.mask = q.mask >> 1;
            d.dac  = kept | (q.mask >> 1);
            if (q.mask[0]) begin
              // overwrites whether read or not
              d.result = kept;
              d.done   = 1'b1;
              if (!d.ien) begin
                d.conv_complete_flag = 1'b1;
              end
              if (d.ien && !d.conv_complete_flag) begin
                d.irq = 1'b1;
              end
              d.state    = d.cont ? ADCSQ_SAMPLE : ADCSQ_IDLE;
              d.tick_cnt = 4'h0;
            end
          end
        end
      endcase
    end
    // level request, dropped only by access or disabling
    d.irq     = d.irq & d.ien;
    d.pwr_off = off;
    d.in_sel  = adcsq_pin_decode(d.chan);
    d.hi_sel  = (d.chan == ADCSQ_CHAN_HIGH_REF);
    d.lo_sel  = (d.chan == ADCSQ_CHAN_LOW_REF);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= ADCSQ_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_rdata        = q.rdata;
  assign o_irq          = q.irq;
  assign o_input_sel    = q.in_sel;
  assign o_high_ref_sel = q.hi_sel;
  assign o_low_ref_sel  = q.lo_sel;
  assign o_power_off    = q.pwr_off;
  assign o_sampling     = q.state[1];
  assign o_dac_code     = q.dac;
  assign o_conv_done    = q.done;

  AST_IRQ_ON_DONE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.done && q.ien && !q.conv_complete_flag |-> o_irq)
    else $error("request missing after completion");

  AST_FLAG_ON_DONE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.done && !q.ien |-> q.conv_complete_flag && !o_irq)
    else $error("completion flag not set");

  AST_FLAG_CLEAR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (rd_res || wr_stat) && !q.ien && !(wr_stat && i_wdata[ADCSQ_IEN_BIT])
      |=> !q.conv_complete_flag || q.done)
    else $error("completion flag not cleared by access");

  AST_IRQ_CLEAR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    clear |=> !o_irq || q.done)
    else $error("request survived clearing access");

  AST_IRQ_HOLD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_irq && !clear && q.ien |=> o_irq)
    else $error("request dropped without access");

  AST_OFF_IDLE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_power_off |-> q.state == ADCSQ_IDLE && !q.pend)
    else $error("converter active while powered off");

  AST_STOP_ABORT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_stop_mode |=> q.state == ADCSQ_IDLE && !q.done)
    else $error("conversion ran in stop mode");

  AST_START: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    wr_stat && !i_stop_mode && (i_wdata[4:0] != ADCSQ_CHAN_OFF)
      |=> q.state == ADCSQ_SAMPLE && q.tick_cnt == 4'h0 && q.div_cnt == 4'h0)
    else $error("status write did not start a conversion");

  AST_MODE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.done |-> (q.cont ? q.state == ADCSQ_SAMPLE : q.state == ADCSQ_IDLE))
    else $error("wrong follow-up after completion");

  AST_PIN_SEL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.chan < ADCSQ_CHAN_PIN_CNT |-> $onehot(o_input_sel) && o_input_sel[q.chan[3:0]])
    else $error("pin select does not match channel code");

  AST_REF_SEL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.chan == ADCSQ_CHAN_HIGH_REF |-> o_high_ref_sel && !o_low_ref_sel && o_input_sel == '0)
    else $error("high reference not selected");

  AST_RESET_VALS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> !q.conv_complete_flag && !q.ien && !q.cont && q.chan == ADCSQ_CHAN_OFF
      && o_power_off && !o_irq && !q.src)
    else $error("register state after reset is wrong");

  AST_RDATA_IDLE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside its read cycle");

  AST_RESULT_READ: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    rd_res |=> o_rdata == $past(q.result))
    else $error("result read returned wrong data");

  AST_STATUS_READ: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rd && i_addr == ADCSQ_ADDR_STATUS
      |=> o_rdata == {$past(q.conv_complete_flag), $past(q.ien), $past(q.cont), $past(q.chan)})
    else $error("status read returned wrong data");

  AST_CLK_READ: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rd && i_addr == ADCSQ_ADDR_CLKCFG
      |=> o_rdata == {$past(q.div), $past(q.src), 4'h0})
    else $error("clock config read returned wrong data");

  AST_RESULT_HOLD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $changed(q.result) |-> q.done)
    else $error("result changed without a completion");

  AST_SAR_RESULT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.done |-> q.result == ($past(i_comp_above) ? $past(q.dac)
                                                : ($past(q.dac) & ~$past(q.mask))))
    else $error("result does not hold the last decision");

  AST_CONV_COMPLETE_FLAG_WRITE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    wr_stat && i_wdata[ADCSQ_IEN_BIT] |=> q.conv_complete_flag == $past(i_wdata[ADCSQ_CONV_COMPLETE_FLAG_BIT]))
    else $error("completion bit did not take the written value");

  AST_CONV_COMPLETE_FLAG_KEEP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.ien && !wr_stat |=> $stable(q.conv_complete_flag))
    else $error("completion bit moved while interrupts enabled");

  AST_IRQ_SUPPRESS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_irq |-> q.ien && !q.conv_complete_flag)
    else $error("request raised with completion bit set");

  AST_IRQ_RISE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(o_irq) |-> q.done)
    else $error("request raised without a completion");

  AST_IRQ_OFF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !q.ien |-> !o_irq)
    else $error("request raised while disabled");

  AST_CONV_COMPLETE_FLAG_RISE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(q.conv_complete_flag) && !q.ien |-> q.done)
    else $error("read-only completion bit set without completion");

  AST_DONE_FROM_APPROX: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.done |-> $past(q.state) == ADCSQ_APPROX)
    else $error("completion outside approximation");

  AST_DONE_PULSE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.done |=> !q.done)
    else $error("completion pulse longer than one cycle");

  AST_START_NO_DONE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    wr_stat |=> !o_conv_done)
    else $error("restarted conversion still completed");

  AST_DAC_FIRST: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.state == ADCSQ_APPROX && $past(q.state) == ADCSQ_SAMPLE
      |-> o_dac_code == 8'h80 && q.mask == 8'h80)
    else $error("approximation did not start at mid scale");

  AST_DIV1_STEP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.src && q.div == 3'h0 && q.state == ADCSQ_APPROX && !i_stop_mode && !wr_stat
      |=> q.mask == ($past(q.mask) >> 1))
    else $error("undivided clock missed a decision");

  AST_DIV16_HOLD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.div[2] && q.div_cnt != 4'hf && q.state == ADCSQ_APPROX && !i_stop_mode && !wr_stat
      |=> $stable(q.mask))
    else $error("divide by 16 ticked early");

  AST_EXT_HOLD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !q.src && !(i_ext_ref_clock && !q.ext_prev) && q.state == ADCSQ_APPROX
      && !i_stop_mode && !wr_stat |=> $stable(q.mask))
    else $error("decision without a reference clock edge");

  AST_IDLE_STAYS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.state == ADCSQ_IDLE && !q.pend && !wr_stat |=> q.state == ADCSQ_IDLE)
    else $error("conversion started without a request");

  AST_OFF_SEL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_power_off |-> o_input_sel == 15'h0000 && !o_high_ref_sel && !o_low_ref_sel && !o_sampling)
    else $error("input selected while powered off");

  AST_PWR_MATCH: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_power_off == (q.chan == ADCSQ_CHAN_OFF))
    else $error("power off does not follow the channel code");

  AST_STOP_KEEP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_stop_mode && !wr_stat && q.state != ADCSQ_IDLE |=> q.pend)
    else $error("aborted conversion not kept for resume");

  AST_RESUME: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.pend && !i_stop_mode && !wr_stat |=> q.state == ADCSQ_SAMPLE)
    else $error("kept conversion did not resume");

  AST_LOW_REF_SEL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    q.chan == ADCSQ_CHAN_LOW_REF |-> o_low_ref_sel && !o_high_ref_sel && o_input_sel == '0)
    else $error("low reference not selected");

endmodule

/* testbench/adcsq_analog_model.sv */
// comparator side model: selected input level compared with the trial code
module adcsq_analog_model (
  input  wire logic [14:0] i_input_sel,
  input  wire logic        i_high_ref_sel,
  input  wire logic        i_low_ref_sel,
  input  wire logic [7:0]  i_dac_code,
  output logic             o_comp_above
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] level;
  logic       valid;

  // pin k sits at 0x11 * k, references at full scale and zero
  always_comb begin
    level = 8'h00;
    valid = i_high_ref_sel | i_low_ref_sel | (|i_input_sel);
    for (int k = 0; k < 15; k++) begin
      if (i_input_sel[k]) begin
        level = 8'(8'h11 * k);
      end
    end
    if (i_high_ref_sel) begin
      level = 8'hff;
    end
  end

  // nothing selected: a moving pattern, never a stale level
  assign o_comp_above = valid ? (level >= i_dac_code) : ^i_dac_code;
endmodule

/* testbench/testbench.sv */
// self-checking bench for the converter sequencer control block
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end

module testbench import adcsq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_clock = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
  logic        i_ext_ref_clock = 0, i_stop_mode = 0;
  logic [15:0] i_addr = '0;
  logic [7:0]  i_wdata = '0;
  logic [1:0]  ext_cnt = '0;
  logic        comp_above;
  logic [7:0]  o_rdata, o_dac_code;
  logic [14:0] o_input_sel;
  logic        o_irq, o_high_ref_sel, o_low_ref_sel, o_power_off, o_sampling, o_conv_done;
  int          err_count = 0, compares = 0;
  logic [4:0]  codes [6] = '{5'h00, 5'h07, 5'h08, 5'h0e, 5'h1d, 5'h1e};

  always #5 i_clock = ~i_clock;
  // free running reference, one rising edge every four clocks
  always @(posedge i_clock) begin
    ext_cnt <= ext_cnt + 2'd1;
    i_ext_ref_clock <= ext_cnt[1];
  end

  adcsq_control dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_ref_clock(i_ext_ref_clock),
    .i_stop_mode(i_stop_mode), .i_comp_above(comp_above), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_input_sel(o_input_sel), .o_high_ref_sel(o_high_ref_sel),
    .o_low_ref_sel(o_low_ref_sel), .o_power_off(o_power_off), .o_sampling(o_sampling),
    .o_dac_code(o_dac_code), .o_conv_done(o_conv_done));

  adcsq_analog_model model (.i_input_sel(o_input_sel), .i_high_ref_sel(o_high_ref_sel),
    .i_low_ref_sel(o_low_ref_sel), .i_dac_code(o_dac_code), .o_comp_above(comp_above));

  task automatic end_sim();
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask

  // counts edges from the launching edge until the completion pulse
  task automatic wait_done(input int lo, input int hi);
    int c = 0;
    do begin
      @(posedge i_clock);
      #1;
      c++;
    end while (o_conv_done !== 1'b1 && c < 2000);
    `CHK(c >= lo && c <= hi, 1'b1)
  endtask

  task automatic quiet(input int cyc);
    int hits = 0;
    repeat (cyc) begin
      @(posedge i_clock);
      #1;
      if (o_conv_done !== 1'b0) hits++;
    end
    `CHK(hits, 0)
  endtask

  task automatic t_reset();
    rd(ADCSQ_ADDR_STATUS, 8'h1f);
    rd(ADCSQ_ADDR_CLKCFG, 8'h00);
    rd(ADCSQ_ADDR_RESULT, 8'h00);
    rd(16'h0040, 8'h00);
    `CHK(o_power_off, 1'b1)
  endtask

  task automatic t_channels();
    logic [4:0] c;
    logic [7:0] lv;
    wr(ADCSQ_ADDR_CLKCFG, 8'h10); // bus clock as source, rate undivided
    wr(ADCSQ_ADDR_STATUS, 8'h00);
    wait_done(16, 16); // warm-up result after power-off is discarded
    foreach (codes[i]) begin
      c = codes[i];
      lv = (c < 5'd15) ? 8'(8'h11 * c) : ((c == 5'h1d) ? 8'hff : 8'h00);
      wr(ADCSQ_ADDR_STATUS, {3'b000, c});
      wait_done(16, 16);
      `CHK(o_input_sel, (c < 5'd15) ? 15'h0001 << c : 15'h0000)
      `CHK({o_high_ref_sel, o_low_ref_sel}, {c == 5'h1d, c == 5'h1e})
      `CHK(o_power_off, 1'b0)
      `CHK(o_dac_code, lv)
      rd(ADCSQ_ADDR_STATUS, {3'b100, c});
      rd(ADCSQ_ADDR_RESULT, lv);
      rd(ADCSQ_ADDR_STATUS, {3'b000, c});
    end
  endtask

  // clock settings only change between conversions
  task automatic t_prescale();
    int r;
    for (int d = 0; d < 8; d++) begin
      if (d == 5 || d == 6) continue;
      r = (d > 3) ? 16 : (1 << d);
      wr(ADCSQ_ADDR_CLKCFG, {3'(d), 5'h10});
      rd(ADCSQ_ADDR_CLKCFG, {3'(d), 5'h10});
      wr(ADCSQ_ADDR_STATUS, 8'h03);
      wait_done(16 * r, 17 * r + 1);
    end
    wr(ADCSQ_ADDR_CLKCFG, 8'h00);
    wr(ADCSQ_ADDR_STATUS, 8'h03);
    wait_done(60, 70);
    wr(ADCSQ_ADDR_CLKCFG, 8'h10);
  endtask

  task automatic t_irq();
    wr(ADCSQ_ADDR_STATUS, 8'h45);
    wait_done(16, 16);
    `CHK(o_irq, 1'b1)
    repeat (5) @(posedge i_clock);
    #1;
    `CHK(o_irq, 1'b1)
    rd(ADCSQ_ADDR_RESULT, 8'h55);
    `CHK(o_irq, 1'b0)
    rd(ADCSQ_ADDR_STATUS, 8'h45);
    wr(ADCSQ_ADDR_STATUS, 8'hc5);
    wait_done(16, 16);
    `CHK(o_irq, 1'b0)
    rd(ADCSQ_ADDR_STATUS, 8'hc5);
    wr(ADCSQ_ADDR_STATUS, 8'h45);
    wait_done(16, 16);
    `CHK(o_irq, 1'b1)
    wr(ADCSQ_ADDR_STATUS, 8'h05);
    #1;
    `CHK(o_irq, 1'b0)
    wait_done(16, 16);
  endtask

  task automatic t_cont();
    wr(ADCSQ_ADDR_STATUS, 8'h27);
    wait_done(16, 16);
    wait_done(16, 17);
    wait_done(16, 17);
    rd(ADCSQ_ADDR_RESULT, 8'h77);
    wr(ADCSQ_ADDR_STATUS, 8'h07);
    wait_done(16, 16);
    quiet(40);
  endtask

  task automatic t_stop();
    wr(ADCSQ_ADDR_STATUS, 8'h05);
    repeat (5) @(posedge i_clock);
    i_stop_mode <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    `CHK(o_sampling, 1'b0)
    quiet(30);
    @(posedge i_clock);
    i_stop_mode <= 1'b0;
    // no new start until the resumed conversion has settled
    wait_done(16, 20);
  endtask

  task automatic t_power();
    wr(ADCSQ_ADDR_STATUS, 8'h1f);
    quiet(40);
    `CHK(o_power_off, 1'b1)
    `CHK(o_input_sel, 15'h0000)
  endtask

  initial begin
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset();
    t_channels();
    t_prescale();
    t_irq();
    t_cont();
    t_stop();
    t_power();
    end_sim();
  end

  initial begin
    #200000;
    err_count++;
    end_sim();
  end
endmodule
